// [hdl/reset_seq_pkg.sv]
package reset_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS       = 100;
  localparam int unsigned FILTER_TIME_NS      = 2000;
  localparam int unsigned FILTER_CYCLES       = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILTER_CNT_W        = 5;
  localparam int unsigned RC_PERIOD_NS        = 32000;
  localparam int unsigned RC_TICK_CYCLES      = RC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned RC_DIV_W            = 9;
  localparam int unsigned POWERUP_TICKS       = 2048;
  localparam int unsigned POWERUP_W           = 11;
  localparam int unsigned INTERNAL_HOLD_NS    = 1600;
  localparam int unsigned INTERNAL_HOLD_CYCLES = INTERNAL_HOLD_NS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W              = 5;
  localparam int unsigned CFG_W               = 16;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CAUSE  = 8'h00;
  localparam logic [7:0] OFS_STACK  = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  localparam int unsigned BIT_BROWNOUT = 0;
  localparam int unsigned BIT_POWERON  = 1;
  localparam int unsigned BIT_POWERDN  = 2;
  localparam int unsigned BIT_WATCHDOG = 3;
  localparam int unsigned BIT_RSTINSTR = 4;
  localparam int unsigned BIT_MISMATCH = 5;
  localparam int unsigned BIT_STK_UNF  = 6;
  localparam int unsigned BIT_STK_FULL = 7;
  localparam int unsigned BIT_STK_EN   = 0;

  localparam logic [7:0]  CAUSE_RESET    = 8'h3C;
  localparam logic        STK_EN_RESET   = 1'b1;
  localparam logic [20:0] RESTART_VECTOR = 21'h0_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_FULL  = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_IDLE  = 2'b10,
    MODE_SLEEP = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    SEQ_RESET   = 2'b00,
    SEQ_POWERUP = 2'b01,
    SEQ_RUN     = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic config_mismatch_flag;
    logic reset_instr_flag;
    logic watchdog_timeout_flag;
    logic powerdown_flag;
    logic poweron_flag;
    logic brownout_flag;
    logic stack_full_flag;
    logic stack_underflow_flag;
  } reset_flags_t;

  typedef struct packed {
    logic watchdog_timeout;
    logic reset_instr;
    logic stack_full;
    logic stack_underflow;
    logic interrupt_wake;
  } core_events_t;

endpackage

// [hdl/pin_glitch_filter.sv]
`timescale 1ns/100ps
module pin_glitch_filter (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      filtered
);
  import reset_seq_pkg::*;

  typedef struct packed {
    logic                    meta;
    logic                    sync;
    logic                    level;
    logic [FILTER_CNT_W-1:0] cnt;
  } filt_state_t;

  filt_state_t st;
  filt_state_t next_st;

  // ----------------------------------------------------------------
  // sync then stability count
  // ----------------------------------------------------------------
  // a change is taken only after it stood for the whole filter time
  always_comb begin
    next_st      = st;
    next_st.meta = pin_in;
    next_st.sync = st.meta;
    if (st.sync != st.level) begin
      if (st.cnt == FILTER_CNT_W'(FILTER_CYCLES - 1)) begin
        next_st.level = st.sync;
        next_st.cnt   = '0;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end else begin
      next_st.cnt = '0; // glitch shorter than filter: discarded
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '{meta: 1'b1, sync: 1'b1, level: 1'b1, cnt: '0};
    end else begin
      st <= next_st;
    end
  end

  assign filtered = st.level;
endmodule

// [hdl/powerup_timer.sv]
`timescale 1ns/100ps
module powerup_timer #(
  parameter int unsigned TICKS = reset_seq_pkg::POWERUP_TICKS
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic restart,
  output logic      running
);
  import reset_seq_pkg::*;

  typedef struct packed {
    logic [RC_DIV_W-1:0]  div;
    logic                 tick;
    logic [POWERUP_W-1:0] cnt;
    logic                 run;
  } timer_state_t;

  timer_state_t st;
  timer_state_t next_st;

  // ----------------------------------------------------------------
  // internal rc clock enable and eleven-bit count
  // ----------------------------------------------------------------
  // no enable input: the delay can not be skipped by anyone
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.div == RC_DIV_W'(RC_TICK_CYCLES - 1)) begin
      next_st.div  = '0;
      next_st.tick = 1'b1; // one pulse per rc period
    end else begin
      next_st.div = st.div + 1'b1;
    end
    if (restart) begin
      next_st.div  = '0; // prescaler too: only full periods after a restart
      next_st.tick = 1'b0;
      next_st.cnt = '0;
      next_st.run = 1'b1;
    end else if (st.run && st.tick) begin
      if (st.cnt == POWERUP_W'(TICKS - 1)) begin
        next_st.run = 1'b0;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '{div: '0, tick: 1'b0, cnt: '0, run: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign running = st.run;
endmodule

// [hdl/reset_source_and_powerup_timer.sv]
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module reset_source_and_powerup_timer #(
  parameter int unsigned POWERUP_TICKS = reset_seq_pkg::POWERUP_TICKS
) (
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [7:0]                        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              ext_reset_n_pin_in,
  output logic                                   ext_reset_n_pin_out,
  output logic                                   ext_reset_n_pin_oe_n,
  input  wire logic                              poweron_detect,
  input  wire logic                              regulator_enable_pin,
  input  wire logic                              regulator_low,
  input  wire logic [reset_seq_pkg::CFG_W-1:0]   config_word,
  input  wire logic [reset_seq_pkg::CFG_W-1:0]   config_shadow,
  input  wire reset_seq_pkg::power_mode_t        power_mode,
  input  wire reset_seq_pkg::core_events_t       core_events,
  output logic                                   core_reset,
  output logic                                   wake_resume,
  output logic      [20:0]                       restart_vector,
  output reset_seq_pkg::reset_flags_t            flags
);
  import reset_seq_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]        meta;       // poweron, regulator enable, regulator low
    logic [2:0]        sync;
    logic              por_q;
    logic              bo_q;
    logic              mm_q;
    logic              pin_q;
    reset_flags_t      flags;
    logic              stk_enable;
    logic [HOLD_W-1:0] hold;
    seq_state_t        seq;
    logic              wake;
    logic              core_reset;
    logic [31:0]       rdata;
    logic              slverr;
  } main_state_t;

  main_state_t st;
  main_state_t next_st;

  logic pin_filtered;
  logic timer_running;
  logic pin_active;
  logic por_now;
  logic bo_now;
  logic mm_now;
  logic sleepish;
  logic wd_reset;
  logic wd_wake;
  logic int_wake;
  logic stk_reset;
  logic internal_ev;
  logic any_source;
  logic timer_restart;
  logic apb_setup;
  logic apb_write;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reserved bits read as zero; unmapped offsets flag an error
  function automatic logic [31:0] read_word(input logic [7:0] addr, input main_state_t s);
    logic [31:0] w;
    w = '0;
    case (addr)
      OFS_CAUSE: begin
        w[BIT_MISMATCH] = s.flags.config_mismatch_flag;
        w[BIT_RSTINSTR] = s.flags.reset_instr_flag;
        w[BIT_WATCHDOG] = s.flags.watchdog_timeout_flag;
        w[BIT_POWERDN]  = s.flags.powerdown_flag;
        w[BIT_POWERON]  = s.flags.poweron_flag;
        w[BIT_BROWNOUT] = s.flags.brownout_flag;
      end
      OFS_STACK: begin
        w[BIT_STK_FULL] = s.flags.stack_full_flag;
        w[BIT_STK_UNF]  = s.flags.stack_underflow_flag;
      end
      OFS_CTRL: begin
        w[BIT_STK_EN] = s.stk_enable;
      end
      OFS_STATUS: begin
        w[4:0] = {s.bo_q, s.mm_q, s.pin_q, s.seq == SEQ_POWERUP, s.core_reset};
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == OFS_CAUSE) || (addr == OFS_STACK) ||
           (addr == OFS_CTRL) || (addr == OFS_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  pin_glitch_filter u_pin_filter (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_in   (ext_reset_n_pin_in),
    .filtered (pin_filtered)
  );

  powerup_timer #(
    .TICKS (POWERUP_TICKS)
  ) u_powerup_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .restart  (timer_restart),
    .running  (timer_running)
  );

  // ----------------------------------------------------------------
  // source levels and event decode
  // ----------------------------------------------------------------
  // power-on and brown-out use the second sync stage only, never the first
  always_comb begin
    pin_active    = ~pin_filtered;
    por_now       = st.sync[0];
    bo_now        = st.sync[1] & st.sync[2];
    mm_now        = (config_word != ~config_shadow);
    sleepish      = (power_mode == MODE_IDLE) || (power_mode == MODE_SLEEP);
    wd_reset      = core_events.watchdog_timeout & ~sleepish;
    wd_wake       = core_events.watchdog_timeout & sleepish;
    int_wake      = core_events.interrupt_wake & (power_mode != MODE_FULL);
    stk_reset     = st.stk_enable & (core_events.stack_full | core_events.stack_underflow);
    internal_ev   = wd_reset | core_events.reset_instr | stk_reset | (mm_now & ~st.mm_q);
    // power-up delay runs only once power-on and brown-out have both gone
    timer_restart = por_now | bo_now;
    any_source    = pin_active | por_now | bo_now | mm_now | (st.hold != '0);
    apb_setup     = psel & ~penable;
    apb_write     = psel & penable & pwrite;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.meta  = {regulator_low, regulator_enable_pin, poweron_detect};
    next_st.sync  = st.meta;
    next_st.por_q = por_now;
    next_st.bo_q  = bo_now;
    next_st.mm_q  = mm_now;
    next_st.pin_q = pin_active;
    next_st.wake  = 1'b0;

    // software writes go first so that a hardware event in the same cycle wins
    if (apb_write) begin
      case (paddr)
        OFS_CAUSE: begin
          next_st.flags.config_mismatch_flag = pwdata[BIT_MISMATCH];
          next_st.flags.reset_instr_flag     = pwdata[BIT_RSTINSTR];
          next_st.flags.poweron_flag         = pwdata[BIT_POWERON];
          next_st.flags.brownout_flag        = pwdata[BIT_BROWNOUT];
        end
        OFS_STACK: begin
          next_st.flags.stack_full_flag      = pwdata[BIT_STK_FULL];
          next_st.flags.stack_underflow_flag = pwdata[BIT_STK_UNF];
        end
        OFS_CTRL: begin
          next_st.stk_enable = pwdata[BIT_STK_EN];
        end
        default: begin
          next_st.stk_enable = st.stk_enable;
        end
      endcase
    end

    // external pin reset, flags depend on the power mode at the time
    if (pin_active && !st.pin_q) begin
      case (power_mode)
        MODE_RUN: begin
          next_st.flags.watchdog_timeout_flag = 1'b1;
        end
        MODE_IDLE, MODE_SLEEP: begin
          next_st.flags.watchdog_timeout_flag = 1'b1;
          next_st.flags.powerdown_flag        = 1'b0;
        end
        default: begin
          next_st.flags = next_st.flags;
        end
      endcase
    end

    // watchdog: reset when awake, resume when asleep
    if (wd_reset) begin
      next_st.flags.watchdog_timeout_flag = 1'b0;
    end
    if (wd_wake) begin
      next_st.flags.watchdog_timeout_flag = 1'b0;
      next_st.flags.powerdown_flag        = 1'b0;
      next_st.wake                        = 1'b1;
    end
    if (int_wake) begin
      next_st.flags.powerdown_flag = 1'b0;
      next_st.wake                 = 1'b1;
    end

    if (core_events.reset_instr) begin
      next_st.flags.reset_instr_flag = 1'b0;
    end

    // stack events: underflow flags even when no reset is taken
    if (core_events.stack_full && st.stk_enable) begin
      next_st.flags.stack_full_flag = 1'b1;
    end
    if (core_events.stack_underflow) begin
      next_st.flags.stack_underflow_flag = 1'b1;
    end

    if (mm_now && !st.mm_q) begin
      next_st.flags.config_mismatch_flag = 1'b0;
    end

    if (bo_now && !st.bo_q) begin
      next_st.flags.reset_instr_flag      = 1'b1;
      next_st.flags.watchdog_timeout_flag = 1'b1;
      next_st.flags.powerdown_flag        = 1'b1;
      next_st.flags.brownout_flag         = 1'b0;
    end

    // power-on last: it overrides every other cause in the same cycle except the config mismatch flag
    if (por_now && !st.por_q) begin
      next_st.flags.reset_instr_flag      = 1'b1;
      next_st.flags.watchdog_timeout_flag = 1'b1;
      next_st.flags.powerdown_flag        = 1'b1;
      next_st.flags.poweron_flag          = 1'b0;
      next_st.flags.brownout_flag         = 1'b0;
      next_st.flags.stack_full_flag       = 1'b0;
      next_st.flags.stack_underflow_flag  = 1'b0;
    end

    // short internal resets are stretched so the core sees them
    if (internal_ev) begin
      next_st.hold = HOLD_W'(INTERNAL_HOLD_CYCLES);
    end else if (st.hold != '0) begin
      next_st.hold = st.hold - 1'b1;
    end

    // sequence: pin low past timer expiry releases as soon as it rises
    if (any_source) begin
      next_st.seq = SEQ_RESET;
    end else if (timer_running) begin
      next_st.seq = SEQ_POWERUP;
    end else begin
      next_st.seq = SEQ_RUN;
    end
    case (next_st.seq)
      SEQ_RESET:   next_st.core_reset = 1'b1;
      SEQ_POWERUP: next_st.core_reset = 1'b1;
      SEQ_RUN:     next_st.core_reset = 1'b0;
      default:     next_st.core_reset = 1'b1;
    endcase

    // read data is fetched in the setup cycle and held for the access
    if (apb_setup) begin
      next_st.rdata  = read_word(paddr, st);
      next_st.slverr = ~is_mapped(paddr);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // sys_rst is the power-on event: flags take their power-on values
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st            <= '0;
      st.flags      <= reset_flags_t'({CAUSE_RESET[5:0], 2'b00});
      st.stk_enable <= STK_EN_RESET;
      st.seq        <= SEQ_RESET;
      st.core_reset <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata               = st.rdata;
  assign pready               = 1'b1; // zero wait states
  assign pslverr              = st.slverr;
  assign ext_reset_n_pin_out  = 1'b1;
  assign ext_reset_n_pin_oe_n = 1'b1;
  assign core_reset           = st.core_reset;
  assign wake_resume          = st.wake;
  assign restart_vector       = RESTART_VECTOR;
  assign flags                = st.flags;
endmodule

// [tb/reset_seq_props.sv]
`timescale 1ns/100ps
module reset_seq_props
  import reset_seq_pkg::*;
#(
  parameter int unsigned POWERUP_TICKS = reset_seq_pkg::POWERUP_TICKS
) (
  input wire logic                        core_clk,
  input wire logic                        sys_rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic                        ext_reset_n_pin_in,
  input wire logic                        ext_reset_n_pin_out,
  input wire logic                        ext_reset_n_pin_oe_n,
  input wire logic                        poweron_detect,
  input wire logic                        regulator_enable_pin,
  input wire logic                        regulator_low,
  input wire logic [reset_seq_pkg::CFG_W-1:0] config_word,
  input wire logic [reset_seq_pkg::CFG_W-1:0] config_shadow,
  input wire reset_seq_pkg::core_events_t core_events,
  input wire logic                        core_reset,
  input wire logic                        wake_resume,
  input wire logic [20:0]                 restart_vector,
  input wire reset_seq_pkg::reset_flags_t flags
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam int unsigned HOLD = POWERUP_TICKS * RC_TICK_CYCLES;
  logic [15:0] since;
  logic [3:0]  sup_hist;
  logic [4:0]  low_run;
  logic        mm;
  logic        cause_wr;
  assign mm = config_word != ~config_shadow;
  assign cause_wr = psel && penable && pwrite && paddr == OFS_CAUSE;
  // cycles since the last timer restart cause, saturating
  always_ff @(posedge core_clk) begin
    if (sys_rst || poweron_detect || (regulator_enable_pin && regulator_low)) since <= '0;
    else if (since != 16'hFFFF) since <= since + 16'h0001;
  end
  // history of supply events, since the flag lags the pins by a few edges
  always_ff @(posedge core_clk) begin
    sup_hist <= sys_rst ? 4'h0 : {sup_hist[2:0], poweron_detect ||
                (regulator_enable_pin && regulator_low)};
    low_run  <= ext_reset_n_pin_in ? 5'h00 : (low_run == 5'h1F ? low_run : low_run + 5'h01);
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wake_pulse;
    !core_reset ##1 !wake_resume;
  endsequence
  sequence s_instr_reset;
    ##[1:2] (core_reset && !flags.reset_instr_flag);
  endsequence
  a_pin_never_driven: assert property (ext_reset_n_pin_oe_n && ext_reset_n_pin_out)
    else $error("reset pin driven by device");
  a_pin_holds_reset: assert property (low_run >= 5'h1A |-> core_reset)
    else $error("low pin left core running");
  a_poweron_clears: assert property ($rose(poweron_detect) |->
    ##[2:5] (!flags.poweron_flag && !flags.brownout_flag))
    else $error("power-on left flags set");
  a_poweron_sw_only: assert property ($rose(flags.poweron_flag) |->
    $past(cause_wr))
    else $error("power-on flag set without write");
  a_brownout_cause: assert property ($fell(flags.brownout_flag) |-> |sup_hist)
    else $error("brown-out flag cleared without cause");
  a_mismatch_reset: assert property (mm [*4] |-> core_reset)
    else $error("mismatch without reset");
  a_mismatch_flag: assert property ($fell(flags.config_mismatch_flag) |->
    $past(mm) || $past(mm, 2))
    else $error("mismatch flag cleared without mismatch");
  a_timer_holds: assert property ($fell(core_reset) |-> since >= HOLD)
    else $error("core released before timer expiry");
  a_wake_no_reset: assert property ($rose(wake_resume) |-> s_wake_pulse)
    else $error("wake pulse malformed");
  a_instr_reset: assert property (core_events.reset_instr && !core_reset |->
    s_instr_reset)
    else $error("reset instruction not taken");
  a_vector_zero: assert property (restart_vector == 21'h0_0000)
    else $error("restart vector not zero");
endmodule
bind reset_source_and_powerup_timer reset_seq_props #(.POWERUP_TICKS(POWERUP_TICKS))
  reset_seq_props_inst (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .ext_reset_n_pin_in, .ext_reset_n_pin_out, .ext_reset_n_pin_oe_n, .poweron_detect,
  .regulator_enable_pin, .regulator_low, .config_word, .config_shadow, .core_events,
  .core_reset, .wake_resume, .restart_vector, .flags);

// [tb/board_supply_model.sv]
`timescale 1ns/100ps
module board_supply_model (
  input  wire logic core_clk,
  output logic      pin_n,
  output logic      poweron_detect,
  output logic      regulator_enable_pin,
  output logic      regulator_low
);
  // ----------------------------------------------------------------
  // board pin and supply monitors
  // ----------------------------------------------------------------
  initial begin
    pin_n = 1'b1;
    poweron_detect = 1'b0;
    regulator_enable_pin = 1'b1;
    regulator_low = 1'b0;
  end
  // one line active for n cycles; pull-up brings the released pin high
  task automatic assert_line(input int k, input int n);
    @(posedge core_clk);
    if (k == 0) pin_n <= 1'b0;
    else if (k == 1) poweron_detect <= 1'b1;
    else regulator_low <= 1'b1;
    repeat (n) @(posedge core_clk);
    pin_n <= 1'b1;
    poweron_detect <= 1'b0;
    regulator_low <= 1'b0;
  endtask
  task automatic set_reg(input bit v);
    @(posedge core_clk);
    regulator_enable_pin <= v;
  endtask
endmodule

// [tb/reset_source_and_powerup_timer_tb.sv]
`timescale 1ns/100ps
module reset_source_and_powerup_timer_tb;
  import reset_seq_pkg::*;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  localparam int TK   = 4;
  localparam int HOLD = TK * RC_TICK_CYCLES;
  logic               core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               pin_n, pin_wire, pin_out, pin_oe_n, core_reset, wake_resume, rst_seen, wk;
  logic               poweron_detect, regulator_enable_pin, regulator_low;
  logic [CFG_W-1:0]   config_word, config_shadow;
  logic [20:0]        restart_vector;
  power_mode_t        power_mode;
  core_events_t       core_events;
  reset_flags_t       flags;
  int                 err_count, n_checks, cyc, n;
  // wired-and: the board (pin_n) and the device (pin_oe_n and pin_out both low) may each pull the pin low
  assign pin_wire = pin_n & (pin_oe_n | pin_out);
  reset_source_and_powerup_timer #(.POWERUP_TICKS(TK)) reset_source_and_powerup_timer_inst (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_reset_n_pin_in(pin_wire), .ext_reset_n_pin_out(pin_out),
    .ext_reset_n_pin_oe_n(pin_oe_n), .poweron_detect, .regulator_enable_pin,
    .regulator_low, .config_word, .config_shadow, .power_mode, .core_events, .core_reset,
    .wake_resume, .restart_vector, .flags);
  board_supply_model board_supply_model_inst (.core_clk, .pin_n, .poweron_detect,
    .regulator_enable_pin, .regulator_low);
  always #50 core_clk = ~core_clk;
  // hang guard and reset watcher
  always @(posedge core_clk) begin
    cyc++;
    if (core_reset === 1'b1) rst_seen <= 1'b1;
    if (wake_resume === 1'b1) wk <= 1'b1;
    if (cyc == 10000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // wait for the core to be let go; the hang guard bounds it
  task automatic wait_rel();
    n = 0;
    while (core_reset !== 1'b0) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic ev(input logic [4:0] e);
    @(posedge core_clk);
    rst_seen = 1'b0;
    wk = 1'b0;
    core_events <= e;
    @(posedge core_clk);
    core_events <= '0;
    repeat (30) @(posedge core_clk);
  endtask
  task automatic pin(input power_mode_t m, input logic [7:0] e);
    power_mode <= m;
    board_supply_model_inst.assert_line(0, 40);
    wait_rel();
    chk("released quickly", 1, n < 30);
    chk("flags after pin", e, flags);
  endtask
  task automatic t_powerup();
    wait_rel();
    chk("powerup hold", 1, n >= HOLD && n < HOLD + 40);
    chk("flags power-on", 8'hF0, flags);
    apb(0, OFS_CAUSE, 0);
    chk("cause reg", CAUSE_RESET, rd);
    apb(0, OFS_CTRL, 0);
    chk("ctrl reg", 1, rd);
    apb(0, 8'h10, 0);
    chk("unmapped", 1, rerr);
    apb(1, OFS_CAUSE, 32'h0000_003F);
    chk("sw set flags", 8'hFC, flags);
    $display("done powerup");
  endtask
  task automatic t_pin();
    board_supply_model_inst.assert_line(0, 10);
    ev(5'h00);
    chk("glitch", 0, rst_seen);
    ev(5'h10);
    chk("wd full", 8'hDC, flags);
    pin(MODE_FULL, 8'hDC);
    pin(MODE_RUN, 8'hFC);
    ev(5'h01);
    chk("int wake", 8'hEC, flags);
    chk("int pulse", 1, wk);
    power_mode <= MODE_IDLE;
    ev(5'h10);
    chk("wd wake", 8'hCC, flags);
    chk("wd pulse", 1, wk);
    chk("wake no reset", 0, rst_seen);
    pin(MODE_SLEEP, 8'hEC);
    power_mode <= MODE_FULL;
    ev(5'h08);
    chk("instr", 8'hAC, flags);
    $display("done pin");
  endtask
  task automatic t_stack();
    apb(1, OFS_CTRL, 0);
    ev(5'h04);
    chk("full off", 8'hAC, flags);
    ev(5'h02);
    chk("unf off", 8'hAD, flags);
    chk("unf no reset", 0, rst_seen);
    apb(1, OFS_CTRL, 1);
    ev(5'h04);
    chk("full on", 8'hAF, flags);
    chk("full reset", 1, rst_seen);
    $display("done stack");
  endtask
  task automatic t_mismatch();
    config_shadow <= config_shadow ^ 16'h0001;
    repeat (10) @(posedge core_clk);
    chk("mm reset", 1, core_reset);
    chk("mm flag", 8'h2F, flags);
    config_shadow <= ~config_word;
    wait_rel();
    $display("done mismatch");
  endtask
  task automatic t_brownout();
    board_supply_model_inst.set_reg(0);
    rst_seen = 1'b0;
    board_supply_model_inst.assert_line(2, 50);
    ev(5'h00);
    chk("bo disabled", 0, rst_seen);
    board_supply_model_inst.set_reg(1);
    board_supply_model_inst.assert_line(2, 20);
    repeat (600) @(posedge core_clk);
    board_supply_model_inst.assert_line(2, 10);
    wait_rel();
    chk("bo restart", 1, n >= HOLD && n < HOLD + 40);
    chk("bo flags", 8'h7B, flags);
    $display("done brownout");
  endtask
  task automatic t_poweron();
    board_supply_model_inst.set_reg(0);
    board_supply_model_inst.assert_line(1, 20);
    wait_rel();
    chk("por flags", 8'h70, flags & 8'h7F);
    $display("done poweron");
  endtask
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    config_word = 16'hA5C3;
    config_shadow = ~16'hA5C3;
    power_mode = MODE_FULL;
    core_events = '0;
    {err_count, n_checks, cyc} = '0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_powerup();
    t_pin();
    t_stack();
    t_mismatch();
    t_brownout();
    t_poweron();
    tally_and_finish();
  end
endmodule
